// ### dv/pevi_interconnect_tb.sv
`include "pevi_regs.vh"
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module pevi_interconnect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst = 1, lvl = 0;
  logic [2:0]  mode = 0;
  logic [8:0]  tsel = 9'h111;
  logic [5:0]  csel = 6'h24, tidx = 6'h01;
  logic [1:0]  lsel = 0;
  logic [14:0] src;
  wire  [2:0]  gtrig, gchan;
  wire         lpt, ract, rstop;
  int          err_total = 0, tests_run = 0;
  pevi_src_model partner (.clock(clock), .lvl(lvl), .src(src));
  pevi_interconnect uut (.clock(clock), .rst(rst), .power_mode(mode),
    .analog_comparator_out(src[14:13]), .general_timer_trgo(src[12:10]),
    .rtc_wakeup_event(src[9]), .rtc_event(src[8]), .clock_source(src[7:4]),
    .pin_in(src[3:0]), .trig_sel(tsel), .trig_src_idx(tidx), .chan_sel(csel),
    .chan_src_idx(6'h00), .lp_trig_sel(lsel), .lp_src_idx(2'h0), .general_timer_trig(gtrig),
    .general_timer_chan(gchan), .low_power_timer_trig(lpt), .route_active(ract),
    .route_stop(rstop));
  task settle(input logic [2:0] m, input logic l);
    @(posedge clock);
    mode <= m;
    lvl <= l;
    repeat (5) @(posedge clock);
    #1;
  endtask
  task t_modes;
    for (int m = 0; m < 6; m++) begin
      settle(m[2:0], 1'b1);
      `CHK("route_active", m < 4, ract)
      `CHK("route_stop", m == 4, rstop)
      `CHK("gen_trig", (m < 4) ? 3'h7 : 3'h0, gtrig)
      `CHK("gen_chan", (m < 4) ? 3'h7 : 3'h0, gchan)
      `CHK("lp_trig", m < 5, lpt)
    end
  endtask
  task t_stop_lp;
    settle(3'h0, 1'b0);
    `CHK("gen_low", 3'h0, gtrig | gchan)
    @(posedge clock);
    lsel <= `PEVI_LSEL_COMP;
    settle(3'h4, 1'b1);
    `CHK("lp_comp", 1'b1, lpt)
    settle(3'h4, 1'b0);
    `CHK("lp_comp", 1'b0, lpt)
  endtask
  task t_sel_routes;
    @(posedge clock);
    tsel <= 9'h113;
    settle(3'h0, 1'b1);
    `CHK("sel_trig", 3'h7, gtrig)
    settle(3'h4, 1'b1);
    `CHK("sel_stop", 3'h0, gtrig)
    @(posedge clock);
    tsel <= 9'h112;
    tidx <= 6'h00;
    settle(3'h0, 1'b1);
    `CHK("wkup_t1_only", 3'h6, gtrig)
    @(posedge clock);
    tsel <= 9'h111;
    settle(3'h2, 1'b1);
    `CHK("self_trig", 3'h6, gtrig)
    @(posedge clock);
    lsel <= `PEVI_LSEL_PIN;
    settle(3'h4, 1'b1);
    `CHK("lp_pin", 1'b1, lpt)
    @(posedge clock);
    lsel <= `PEVI_LSEL_NONE;
    settle(3'h4, 1'b1);
    `CHK("lp_none", 1'b0, lpt)
  endtask
  task wrap_up;
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #2.5 clock = ~clock;
  initial begin
    repeat (2) @(posedge clock);
    rst <= 0;
    t_modes;
    t_stop_lp;
    t_sel_routes;
    wrap_up;
  end
  initial begin
    #5000;
    err_total++;
    wrap_up;
  end
endmodule // pevi_interconnect_tb
bind pevi_interconnect pevi_sva #(.NT(NT), .NP(NP)) u_sva (.clock(clock), .rst(rst),
  .route_active(route_active), .route_stop(route_stop), .rtc_event(rtc_event),
  .rtc_wakeup_event(rtc_wakeup_event), .low_power_timer_trig(low_power_timer_trig),
  .power_mode(power_mode), .lp_trig_sel(lp_trig_sel), .pin_in(pin_in),
  .general_timer_trgo(general_timer_trgo), .general_timer_trig(general_timer_trig),
  .general_timer_chan(general_timer_chan), .trig_sel(trig_sel),
  .trig_src_idx(trig_src_idx), .chan_sel(chan_sel), .chan_src_idx(chan_src_idx));

// ### dv/pevi_src_model.sv
module pevi_src_model (
  input  wire logic        clock,
  input  wire logic        lvl,
  output var  logic [14:0] src
);
  timeunit 1ns;
  timeprecision 1ps;
  // every source follows lvl one edge later
  initial src = '0;
  always @(posedge clock) src <= {15{lvl}};
endmodule // pevi_src_model

// ### dv/pevi_sva.sv
`include "pevi_regs.vh"
module pevi_sva #(
  parameter NT = 3,
  parameter NP = 4
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              route_active,
  input wire logic              route_stop,
  input wire logic              rtc_event,
  input wire logic              rtc_wakeup_event,
  input wire logic              low_power_timer_trig,
  input wire logic [2:0]        power_mode,
  input wire logic [1:0]        lp_trig_sel,
  input wire logic [NP-1:0]     pin_in,
  input wire logic [NT-1:0]     general_timer_trgo,
  input wire logic [NT-1:0]     general_timer_trig,
  input wire logic [NT-1:0]     general_timer_chan,
  input wire logic [NT*3-1:0]   trig_sel,
  input wire logic [NT*2-1:0]   trig_src_idx,
  input wire logic [NT*2-1:0]   chan_sel,
  input wire logic [NT*2-1:0]   chan_src_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic live = route_active | route_stop;
  sequence s_gen3; route_active [*3]; endsequence
  sequence s_lp3; live [*3]; endsequence
  a_mode_active: assert property (
    !$past(rst) |-> route_active == ($past(power_mode) < `PEVI_MODE_STOP)) else $error("gate");
  a_mode_stop: assert property (
    !$past(rst) |-> route_stop == ($past(power_mode) == `PEVI_MODE_STOP)) else $error("stop");
  a_stop_excl: assert property (
    route_stop |-> !route_active) else $error("both live");
  a_gen_gated: assert property (
    !route_active |=> general_timer_trig == '0 && general_timer_chan == '0) else $error("off");
  a_tim_chain: assert property (
    route_active ##1 ($past(trig_sel[2:0]) == `PEVI_TSEL_TIMER && $past(trig_src_idx[1:0]) == 2'h1)
    |-> general_timer_trig[0] == $past(general_timer_trgo[1])) else $error("chain");
  a_rtc_wakeup: assert property (
    s_gen3 ##1 ($past(trig_sel[5:3]) == `PEVI_TSEL_RTC_WKUP)
    |-> general_timer_trig[1] == $past(rtc_wakeup_event, 3)) else $error("wakeup");
  a_pin_chan: assert property (
    s_gen3 ##1 ($past(chan_sel[1:0]) == `PEVI_CSEL_PIN && $past(chan_src_idx[1:0]) == 2'h0)
    |-> general_timer_chan[0] == $past(pin_in[0], 3)) else $error("pin chan");
  a_lp_rtc: assert property (
    s_lp3 ##1 ($past(lp_trig_sel) == `PEVI_LSEL_RTC)
    |-> low_power_timer_trig == $past(rtc_event, 3)) else $error("lp rtc");
endmodule // pevi_sva

// ### hw/pevi_interconnect.v
// Overview of operation
// - every route is gated by the power mode and only routes defined for that mode pass.
// - a general timer trigger output reaches another general timer trigger except in stop.
// - the rtc periodic wakeup reaches the second general timer trigger except in stop.
// - rtc events reach the low power timer trigger in every valid mode including stop.
// - a selected clock source feeds a general timer input channel except in stop.
// - pins reach general timer channels and triggers except in stop, low power timer in every valid mode.
`include "pevi_regs.vh"
module pevi_interconnect #(
  parameter NT = 3,
  parameter NC = 2,
  parameter NP = 4,
  parameter NK = 4
) (
  input  wire                        clock,
  input  wire                        rst,
  input  wire [`PEVI_MODE_W-1:0]     power_mode,
  input  wire [NC-1:0]               analog_comparator_out,
  input  wire [NT-1:0]               general_timer_trgo,
  input  wire                        rtc_wakeup_event,
  input  wire                        rtc_event,
  input  wire [NK-1:0]               clock_source,
  input  wire [NP-1:0]               pin_in,
  input  wire [NT*`PEVI_TSEL_W-1:0]  trig_sel,
  input  wire [NT*2-1:0]             trig_src_idx,
  input  wire [NT*`PEVI_CSEL_W-1:0]  chan_sel,
  input  wire [NT*2-1:0]             chan_src_idx,
  input  wire [`PEVI_LSEL_W-1:0]     lp_trig_sel,
  input  wire [1:0]                  lp_src_idx,
  output wire [NT-1:0]               general_timer_trig,
  output wire [NT-1:0]               general_timer_chan,
  output wire                        low_power_timer_trig,
  output wire                        route_active,
  output wire                        route_stop
);
  localparam SW = NC + 2 + NK + NP;
  localparam SECOND_TIMER = 1;

  wire [SW-1:0] ext_s;
  wire [NC-1:0] comp_s;
  wire          wkup_s;
  wire          rtc_s;
  wire [NK-1:0] clk_s;
  wire [NP-1:0] pin_s;

  // all external sources except general_timer_trgo pass two flops
  pevi_sync #(.W(SW)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({analog_comparator_out, rtc_wakeup_event, rtc_event, clock_source, pin_in}),
    .sync_out (ext_s)
  );
  assign pin_s  = ext_s[NP-1:0];
  assign clk_s  = ext_s[NP+NK-1:NP];
  assign rtc_s  = ext_s[NP+NK];
  assign wkup_s = ext_s[NP+NK+1];
  assign comp_s = ext_s[SW-1:NP+NK+2];

  // mode decode: bit0 route group live outside stop, bit1 live in stop
  function [1:0] mode_gate;
    input [`PEVI_MODE_W-1:0] m;
    begin
      case (m)
        `PEVI_MODE_RUN, `PEVI_MODE_SLEEP,
        `PEVI_MODE_LP_RUN, `PEVI_MODE_LP_SLEEP: mode_gate = 2'h3;
        `PEVI_MODE_STOP: mode_gate = 2'h2;
        default: mode_gate = 2'h0;
      endcase
    end
  endfunction

  function pick;
    input [31:0] vec;
    input [1:0]  idx;
    begin
      pick = vec[idx];
    end
  endfunction

  reg         gen_en_q;
  reg         lp_en_q;
  reg         stop_q;
  wire [1:0]  gate_d = mode_gate(power_mode);
  wire        gen_en_d;
  wire        lp_en_d;
  wire        stop_d;

  // general routes live only outside stop
  assign gen_en_d = gate_d[`PEVI_EN_ACTIVE];
  // low power timer routes live in every valid mode
  assign lp_en_d  = gate_d[`PEVI_EN_ACTIVE] | gate_d[`PEVI_EN_STOP];
  // stop: only the low power timer routes stay live
  assign stop_d   = gate_d[`PEVI_EN_STOP] & ~gate_d[`PEVI_EN_ACTIVE];

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      gen_en_q <= 1'b0;
      lp_en_q  <= 1'b0;
      stop_q   <= 1'b0;
    end else begin
      gen_en_q <= gen_en_d;
      lp_en_q  <= lp_en_d;
      stop_q   <= stop_d;
    end
  end
  assign route_active = gen_en_q;
  assign route_stop   = stop_q;

  // sources padded to the width taken by pick
  wire [31:0] trgo_pad = {{(32-NT){1'b0}}, general_timer_trgo};
  wire [31:0] comp_pad = {{(32-NC){1'b0}}, comp_s};
  wire [31:0] pin_pad  = {{(32-NP){1'b0}}, pin_s};
  wire [31:0] clk_pad  = {{(32-NK){1'b0}}, clk_s};

  wire [NT-1:0] trig_v;
  wire [NT-1:0] chan_v;

  genvar t;
  generate
    for (t = 0; t < NT; t = t + 1) begin : g_tmr
      wire [`PEVI_TSEL_W-1:0] ts = trig_sel[t*`PEVI_TSEL_W +: `PEVI_TSEL_W];
      wire [`PEVI_CSEL_W-1:0] cs = chan_sel[t*`PEVI_CSEL_W +: `PEVI_CSEL_W];
      wire [1:0]              ti = trig_src_idx[t*2 +: 2];
      wire [1:0]              ci = chan_src_idx[t*2 +: 2];
      // candidate trigger sources, a timer never triggers itself
      wire                    tmr_src   = pick(trgo_pad, ti) & (ti != t);
      wire                    wkup_src  = (t == SECOND_TIMER) & wkup_s;
      wire                    comp_tsrc = pick(comp_pad, ti);
      wire                    pin_tsrc  = pick(pin_pad, ti);
      // candidate input channel sources
      wire                    pin_csrc  = pick(pin_pad, ci);
      wire                    comp_csrc = pick(comp_pad, ci);
      wire                    clk_csrc  = pick(clk_pad, ci);
      reg                     tr_d;
      reg                     ch_d;
      reg                     tr_q;
      reg                     ch_q;

      always @* begin
        case (ts)
          `PEVI_TSEL_TIMER:    tr_d = tmr_src;
          `PEVI_TSEL_RTC_WKUP: tr_d = wkup_src;
          `PEVI_TSEL_COMP:     tr_d = comp_tsrc;
          `PEVI_TSEL_PIN:      tr_d = pin_tsrc;
          default:             tr_d = 1'b0;
        endcase
      end

      always @* begin
        case (cs)
          `PEVI_CSEL_PIN:   ch_d = pin_csrc;
          `PEVI_CSEL_COMP:  ch_d = comp_csrc;
          `PEVI_CSEL_CLOCK: ch_d = clk_csrc;
          default:          ch_d = 1'b0;
        endcase
      end

      always @(posedge clock or posedge rst) begin
        if (rst) begin
          tr_q <= 1'b0;
        end else begin
          tr_q <= tr_d & gen_en_q;
        end
      end

      always @(posedge clock or posedge rst) begin
        if (rst) begin
          ch_q <= 1'b0;
        end else begin
          ch_q <= ch_d & gen_en_q;
        end
      end

      assign trig_v[t] = tr_q;
      assign chan_v[t] = ch_q;
    end
  endgenerate

  // low power timer trigger, live in stop as well
  wire lp_comp_src = pick(comp_pad, lp_src_idx);
  wire lp_pin_src  = pick(pin_pad, lp_src_idx);
  reg  lp_d;
  reg  lp_q;

  always @* begin
    case (lp_trig_sel)
      `PEVI_LSEL_RTC:  lp_d = rtc_s;
      `PEVI_LSEL_COMP: lp_d = lp_comp_src;
      `PEVI_LSEL_PIN:  lp_d = lp_pin_src;
      default:         lp_d = 1'b0;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lp_q <= 1'b0;
    end else begin
      lp_q <= lp_d & lp_en_q;
    end
  end

  assign general_timer_trig   = trig_v;
  assign general_timer_chan   = chan_v;
  assign low_power_timer_trig = lp_q;
endmodule // pevi_interconnect

// ### hw/pevi_regs.vh
`ifndef PEVI_REGS_VH
`define PEVI_REGS_VH
// power mode codes on pevi power_mode input
`define PEVI_MODE_W        3
`define PEVI_MODE_RUN      3'h0
`define PEVI_MODE_SLEEP    3'h1
`define PEVI_MODE_LP_RUN   3'h2
`define PEVI_MODE_LP_SLEEP 3'h3
`define PEVI_MODE_STOP     3'h4
// gate enable bit positions
`define PEVI_EN_ACTIVE     0
`define PEVI_EN_STOP       1
// trigger select codes for general timer trigger input
`define PEVI_TSEL_W        3
`define PEVI_TSEL_NONE     3'h0
`define PEVI_TSEL_TIMER    3'h1
`define PEVI_TSEL_RTC_WKUP 3'h2
`define PEVI_TSEL_COMP     3'h3
`define PEVI_TSEL_PIN      3'h4
// input channel select codes for general timer channel
`define PEVI_CSEL_W        2
`define PEVI_CSEL_PIN      2'h0
`define PEVI_CSEL_COMP     2'h1
`define PEVI_CSEL_CLOCK    2'h2
`define PEVI_CSEL_NONE     2'h3
// low power timer trigger select
`define PEVI_LSEL_W        2
`define PEVI_LSEL_RTC      2'h0
`define PEVI_LSEL_COMP     2'h1
`define PEVI_LSEL_PIN      2'h2
`define PEVI_LSEL_NONE     2'h3
`endif

// ### hw/pevi_sync.v
// two-flop synchroniser for a vector of asynchronous inputs
module pevi_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // pevi_sync
